// ===== rtl/pmsc_pkg.sv
package pmsc_pkg;
	// ----------------------------------------------------------------
	// widths and layouts
	// ----------------------------------------------------------------
	localparam int ADDR_W      = 32;
	localparam int SEL_W       = 16;
	localparam int SEL_RPL_LSB = 0;
	localparam int SEL_TI_BIT  = 2;
	localparam int SEL_IDX_LSB = 3;
	localparam int DESC_SIZE   = 8;
	localparam int GATE_SIZE   = 8;

	// descriptor word 1 fields (upper 32 bits)
	localparam int DSC_DPL_LSB  = 13;
	localparam int DSC_TYPE_LSB = 8;
	localparam int DSC_PRES_BIT = 15;

	// gate type codes
	localparam logic [3:0] TYP_CALL16 = 4'h4;
	localparam logic [3:0] TYP_TASK   = 4'h5;
	localparam logic [3:0] TYP_INT16  = 4'h6;
	localparam logic [3:0] TYP_TRAP16 = 4'h7;
	localparam logic [3:0] TYP_CALL32 = 4'hC;
	localparam logic [3:0] TYP_INT32  = 4'hE;
	localparam logic [3:0] TYP_TRAP32 = 4'hF;

	// task state segment byte offsets
	localparam logic [31:0] TSS_ESP0 = 32'h0000_0004;
	localparam logic [31:0] TSS_SS0  = 32'h0000_0008;
	localparam logic [31:0] TSS_CR3  = 32'h0000_001C;
	localparam logic [31:0] TSS_EIP  = 32'h0000_0020;
	localparam logic [31:0] TSS_FLG  = 32'h0000_0024;
	localparam logic [31:0] TSS_LDT  = 32'h0000_0060;
	localparam int TSS_STK_STRIDE = 8;

	// paging fields
	localparam int PG_DIR_LSB = 22;
	localparam int PG_TBL_LSB = 12;
	localparam int PG_PRES_BIT = 0;

	// reset values
	localparam logic [31:0] RST_ZERO = 32'h0000_0000;
	localparam logic [1:0]  RST_CPL  = 2'h0;

	// fault codes
	localparam logic [2:0] FLT_NONE = 3'h0;
	localparam logic [2:0] FLT_PROT = 3'h1;
	localparam logic [2:0] FLT_PAGE = 3'h2;
	localparam logic [2:0] FLT_NOTP = 3'h3;

	typedef enum logic [1:0] {
		PMSC_OP_ACCESS,
		PMSC_OP_CALL,
		PMSC_OP_INTR,
		PMSC_OP_TASK
	} pmsc_op_t;

	// selector index times descriptor size, plus table base
	function automatic logic [31:0] pmsc_entry(input logic [31:0] base, input logic [15:0] sel);
		pmsc_entry = base + {16'h0000, sel[15:3], 3'h0};
	endfunction
endpackage

// ===== rtl/pmsc_priv_chk.sv
`timescale 1ns/1ps
module pmsc_priv_chk
	import pmsc_pkg::*;
(
	// privilege levels
	input  wire logic [1:0] cpl_in,
	input  wire logic [1:0] gate_dpl_in,
	input  wire logic [1:0] tgt_dpl_in,
	input  wire logic       is_gate_in,
	// verdict
	output logic            ok_out,
	output logic            lvl_change_out
);
	// numerically larger level means less privilege
	always_comb begin
		if (is_gate_in) begin
			ok_out = (cpl_in <= gate_dpl_in) && (tgt_dpl_in <= cpl_in);
		end else begin
			ok_out = (cpl_in <= tgt_dpl_in);
		end
		lvl_change_out = is_gate_in && (tgt_dpl_in != cpl_in);
	end
endmodule

// ===== rtl/pmsc_pager.sv
`timescale 1ns/1ps
module pmsc_pager
	import pmsc_pkg::*;
(
	// linear address split
	input  wire logic [31:0] lin_in,
	input  wire logic [31:0] dir_base_in,
	input  wire logic [31:0] pde_in,
	input  wire logic [31:0] pte_in,
	// entry addresses and final address
	output logic [31:0]      pde_addr_out,
	output logic [31:0]      pte_addr_out,
	output logic [31:0]      phys_out
);
	always_comb begin
		pde_addr_out = {dir_base_in[31:12], lin_in[31:PG_DIR_LSB], 2'h0};
		pte_addr_out = {pde_in[31:12], lin_in[PG_DIR_LSB-1:PG_TBL_LSB], 2'h0};
		phys_out     = {pte_in[31:12], lin_in[PG_TBL_LSB-1:0]};
	end
endmodule

// ===== rtl/pmsc_core.sv
// What this block does
// - after reset the block runs in real-address mode until software sets protection.
// - protection enable flag selects real-address or protected translation.
// - protected accesses always go through a global or local table descriptor.
// - selector splits into index, table-choice bit and requested level.
// - linear address is descriptor base plus supplied offset.
// - segment is reachable only if its level permits the current privilege level; task requests and interrupt task gates are not checked.
// - global table base and local table reference are held in registers.
// - gate calls may only go to same or more privileged code.
// - gate call checks level against gate and target; takes selector and offset from gate.
// - a level-changing gate call loads the new stack from the current state segment.
// - gates carry 16-bit or 32-bit targets in either direction.
// - state segment holds registers, flags, pointer, level 0-2 stacks, local table, page base.
// - task switch saves state, loads task register, fetches new segment, restores, resumes.
// - task gate designates a state segment and causes a task switch.
// - vectors come from internal hardware, external controller or software.
// - vector indexes the interrupt table whose base is held in a register.
// - interrupt and trap gates enter like call gates; task gates by task switch.
// - without paging the linear address is the physical address.
// - with paging the linear address splits into directory, table and frame offsets.
// - directory base comes from a register; entries give table and frame bases.
`timescale 1ns/1ps
module pmsc_core
	import pmsc_pkg::*;
(
	// clock and reset
	input  wire logic        sys_clk_in,
	input  wire logic        arst_n_in,
	// control register writes
	input  wire logic        ctl_wr_in,
	input  wire logic        prot_en_in,
	input  wire logic        paging_en_in,
	input  wire logic [31:0] dir_base_in,
	input  wire logic [31:0] gtab_base_in,
	input  wire logic [31:0] itab_base_in,
	input  wire logic [15:0] ltab_sel_in,
	input  wire logic [31:0] ltab_base_in,
	input  wire logic [15:0] task_sel_in,
	// request
	input  wire logic        req_valid_in,
	output logic             req_ready_out,
	input  wire logic [1:0]  req_op_in,
	input  wire logic [15:0] req_sel_in,
	input  wire logic [31:0] req_off_in,
	input  wire logic [7:0]  req_vec_in,
	input  wire logic [1:0]  req_vec_src_in,
	// memory port
	output logic             mem_rd_out,
	output logic             mem_wr_out,
	output logic [31:0]      mem_addr_out,
	output logic [31:0]      mem_wdata_out,
	input  wire logic        mem_ack_in,
	input  wire logic [31:0] mem_rdata_in,
	// results
	output logic             done_out,
	output logic [2:0]       fault_out,
	output logic [31:0]      phys_addr_out,
	output logic [15:0]      code_sel_out,
	output logic [31:0]      ip_out,
	output logic [15:0]      stack_sel_out,
	output logic [31:0]      stack_ptr_out,
	output logic [1:0]       cpl_out,
	output logic             prot_mode_out,
	output logic             code32_out
);
	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	typedef enum logic [3:0] {
		S_IDLE, S_GDESC0, S_GDESC1, S_TDESC0, S_TDESC1,
		S_STK_SP, S_STK_SS, S_SAVE, S_TSS_RD, S_PDE, S_PTE, S_DONE
	} pmsc_st_t;

	pmsc_st_t    st_q, st_d;
	logic        pe_q, pe_d, pg_q, pg_d;
	logic [31:0] cr3_q, cr3_d, gtab_q, gtab_d, itab_q, itab_d, ltab_q, ltab_d;
	logic [15:0] lsel_q, lsel_d, tr_q, tr_d;
	logic [1:0]  cpl_q, cpl_d;
	logic [1:0]  op_q, op_d;
	logic [15:0] sel_q, sel_d;
	logic [31:0] off_q, off_d;
	logic [31:0] w0_q, w0_d, w1_q, w1_d, lin_q, lin_d, pde_q, pde_d;
	logic [31:0] ip_q, ip_d, sp_q, sp_d, phys_q, phys_d;
	logic [15:0] cs_q, cs_d, ss_q, ss_d;
	logic [2:0]  flt_q, flt_d;
	logic [3:0]  cnt_q, cnt_d;
	logic        c32_q, c32_d, gate_q, gate_d;
	logic [31:0] tss_base;
	logic [3:0]  gtype;
	logic        pk_ok, pk_chg;
	logic [31:0] pde_a, pte_a, pg_phys;
	logic [31:0] tss_cur_q, tss_cur_d;

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	assign gtype    = w1_q[DSC_TYPE_LSB+3:DSC_TYPE_LSB];
	assign tss_base = {w1_q[31:24], w1_q[7:0], w0_q[31:16]};

	pmsc_priv_chk u_chk (
		.cpl_in         (cpl_q),
		.gate_dpl_in    (w1_q[DSC_DPL_LSB+1:DSC_DPL_LSB]),
		.tgt_dpl_in     (gate_q ? w1_q[DSC_DPL_LSB+1:DSC_DPL_LSB] : w1_q[DSC_DPL_LSB+1:DSC_DPL_LSB]),
		.is_gate_in     (1'b0),
		.ok_out         (pk_ok),
		.lvl_change_out ()
	);

	logic       gk_ok;
	logic [1:0] gate_dpl_q, gate_dpl_d;
	pmsc_priv_chk u_gchk (
		.cpl_in         (cpl_q),
		.gate_dpl_in    (gate_dpl_q),
		.tgt_dpl_in     (w1_q[DSC_DPL_LSB+1:DSC_DPL_LSB]),
		.is_gate_in     (1'b1),
		.ok_out         (gk_ok),
		.lvl_change_out (pk_chg)
	);

	pmsc_pager u_pg (
		.lin_in       (lin_q),
		.dir_base_in  (cr3_q),
		.pde_in       (pde_q),
		.pte_in       (mem_rdata_in),
		.pde_addr_out (pde_a),
		.pte_addr_out (pte_a),
		.phys_out     (pg_phys)
	);

	// segment descriptor address: global or local table by selector bit
	function automatic logic [31:0] seg_desc(input logic [15:0] s, input logic [31:0] g, input logic [31:0] l);
		seg_desc = pmsc_entry(s[SEL_TI_BIT] ? l : g, s);
	endfunction

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb begin
		st_d = st_q; pe_d = pe_q; pg_d = pg_q; cr3_d = cr3_q; gtab_d = gtab_q;
		itab_d = itab_q; ltab_d = ltab_q; lsel_d = lsel_q; tr_d = tr_q; cpl_d = cpl_q;
		op_d = op_q; sel_d = sel_q; off_d = off_q; w0_d = w0_q; w1_d = w1_q;
		lin_d = lin_q; pde_d = pde_q; ip_d = ip_q; sp_d = sp_q; phys_d = phys_q;
		cs_d = cs_q; ss_d = ss_q; flt_d = flt_q; cnt_d = cnt_q; c32_d = c32_q;
		gate_d = gate_q; gate_dpl_d = gate_dpl_q;
		mem_rd_out = 1'b0; mem_wr_out = 1'b0; mem_addr_out = RST_ZERO; mem_wdata_out = RST_ZERO;
		req_ready_out = 1'b0;
		if (ctl_wr_in && st_q == S_IDLE) begin
			pe_d = prot_en_in;
			pg_d = paging_en_in;
			cr3_d = dir_base_in;
			gtab_d = gtab_base_in;
			ltab_d = ltab_base_in;
			lsel_d = ltab_sel_in;
			itab_d = itab_base_in;
			tr_d = task_sel_in;
		end
		case (st_q)
			S_IDLE: begin
				req_ready_out = !ctl_wr_in;
				if (req_valid_in && !ctl_wr_in) begin
					op_d = req_op_in; sel_d = req_sel_in; off_d = req_off_in; flt_d = FLT_NONE;
					gate_d = 1'b0;
					if (!pe_q) begin
						lin_d = {12'h000, req_sel_in, 4'h0} + req_off_in;
						st_d = S_DONE;
						phys_d = {12'h000, req_sel_in, 4'h0} + req_off_in;
					end else if (req_op_in == 2'(PMSC_OP_INTR)) begin
						sel_d = {5'h00, req_vec_in, 3'h0}; // any source, same table walk
						st_d = S_GDESC0;
					end else begin
						st_d = S_GDESC0;
					end
				end
			end
			S_GDESC0, S_GDESC1: begin
				mem_rd_out = 1'b1;
				if (op_q == 2'(PMSC_OP_INTR) && !gate_q)
					mem_addr_out = pmsc_entry(itab_q, sel_q) + (st_q == S_GDESC1 ? 32'h4 : 32'h0);
				else if (op_q == 2'(PMSC_OP_TASK) || gtype == TYP_TASK && gate_q)
					mem_addr_out = pmsc_entry(gtab_q, sel_q) + (st_q == S_GDESC1 ? 32'h4 : 32'h0);
				else
					mem_addr_out = seg_desc(sel_q, gtab_q, ltab_q) + (st_q == S_GDESC1 ? 32'h4 : 32'h0);
				if (mem_ack_in) begin
					if (st_q == S_GDESC0) begin
						w0_d = mem_rdata_in; st_d = S_GDESC1;
					end else begin
						w1_d = mem_rdata_in; st_d = S_TDESC0;
					end
				end
			end
			S_TDESC0: begin
				// first descriptor in hand: decide by request kind and descriptor type
				if (!w1_q[DSC_PRES_BIT]) begin
					flt_d = FLT_NOTP; st_d = S_DONE;
				end else if (op_q == 2'(PMSC_OP_TASK) || gate_q && gtype == TYP_TASK) begin
					st_d = S_SAVE; cnt_d = 4'h0;
				end else if (!gate_q && (op_q == 2'(PMSC_OP_CALL) || op_q == 2'(PMSC_OP_INTR))) begin
					gate_dpl_d = w1_q[DSC_DPL_LSB+1:DSC_DPL_LSB];
					if (op_q == 2'(PMSC_OP_CALL) && !pk_ok) begin
						flt_d = FLT_PROT; st_d = S_DONE;
					end else if (gtype == TYP_TASK) begin
						// the gate names a state segment: the second pass runs as a task switch
						sel_d = w0_q[31:16]; op_d = 2'(PMSC_OP_TASK); gate_d = 1'b1; st_d = S_GDESC0;
					end else begin
						// target selector and offset from gate, width by type
						sel_d = w0_q[31:16];
						off_d = {w1_q[31:16], w0_q[15:0]};
						c32_d = gtype[3];
						gate_d = 1'b1; st_d = S_GDESC0;
					end
				end else if (gate_q) begin
					if (!gk_ok) begin
						flt_d = FLT_PROT; st_d = S_DONE;
					end else begin
						cs_d = sel_q; ip_d = off_q;
						if (pk_chg) begin
							cpl_d = w1_q[DSC_DPL_LSB+1:DSC_DPL_LSB]; st_d = S_STK_SP;
						end else begin
							st_d = S_DONE;
						end
					end
				end else begin
					if (!pk_ok) begin
						flt_d = FLT_PROT; st_d = S_DONE;
					end else begin
						lin_d = {w1_q[31:24], w1_q[7:0], w0_q[31:16]} + off_q;
						st_d = S_TDESC1;
					end
				end
			end
			S_TDESC1: begin
				if (pg_q) begin
					st_d = S_PDE;
				end else begin
					phys_d = lin_q; st_d = S_DONE;
				end
			end
			S_PDE, S_PTE: begin
				mem_rd_out = 1'b1;
				mem_addr_out = (st_q == S_PDE) ? pde_a : pte_a;
				if (mem_ack_in) begin
					if (!mem_rdata_in[PG_PRES_BIT]) begin
						flt_d = FLT_PAGE; st_d = S_DONE;
					end else if (st_q == S_PDE) begin
						pde_d = mem_rdata_in; st_d = S_PTE;
					end else begin
						phys_d = pg_phys; st_d = S_DONE;
					end
				end
			end
			S_STK_SP, S_STK_SS: begin
				// new level's stack from the current state segment
				mem_rd_out = 1'b1;
				mem_addr_out = tss_cur_q + (st_q == S_STK_SP ? TSS_ESP0 : TSS_SS0)
					+ {28'h0000000, cpl_q, 2'h0} * 32'(TSS_STK_STRIDE / 4);
				if (mem_ack_in) begin
					if (st_q == S_STK_SP) begin
						sp_d = mem_rdata_in; st_d = S_STK_SS;
					end else begin
						ss_d = mem_rdata_in[15:0]; st_d = S_DONE;
					end
				end
			end
			S_SAVE: begin
				// step 1: save pointer, and code selector at the flags offset, into current state segment
				mem_wr_out = 1'b1;
				mem_addr_out = tss_cur_q + (cnt_q[0] ? TSS_FLG : TSS_EIP);
				mem_wdata_out = cnt_q[0] ? {16'h0000, cs_q} : ip_q;
				if (mem_ack_in) begin
					cnt_d = cnt_q + 4'h1;
					if (cnt_q[0]) begin
						tr_d = sel_q; cnt_d = 4'h0; st_d = S_TSS_RD; // step 2
					end
				end
			end
			S_TSS_RD: begin
				// steps 3-4: restore pointer, page base, local table
				mem_rd_out = 1'b1;
				case (cnt_q[1:0])
					2'h0: mem_addr_out = tss_base + TSS_EIP;
					2'h1: mem_addr_out = tss_base + TSS_CR3;
					default: mem_addr_out = tss_base + TSS_LDT;
				endcase
				if (mem_ack_in) begin
					cnt_d = cnt_q + 4'h1;
					case (cnt_q[1:0])
						2'h0: ip_d = mem_rdata_in;
						2'h1: cr3_d = mem_rdata_in;
						default: begin
							lsel_d = mem_rdata_in[15:0]; st_d = S_DONE; // step 5
						end
					endcase
				end
			end
			S_DONE: st_d = S_IDLE;
			default: st_d = S_IDLE;
		endcase
	end

	// base of current state segment, latched at each switch
	always_comb begin
		tss_cur_d = tss_cur_q;
		if (st_q == S_TSS_RD && cnt_q == 4'h0)
			tss_cur_d = tss_base;
	end

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			st_q <= S_IDLE; pe_q <= 1'b0; pg_q <= 1'b0;
			cr3_q <= RST_ZERO; gtab_q <= RST_ZERO; itab_q <= RST_ZERO; ltab_q <= RST_ZERO;
			lsel_q <= 16'h0000; tr_q <= 16'h0000; cpl_q <= RST_CPL; op_q <= 2'h0;
			sel_q <= 16'h0000; off_q <= RST_ZERO; w0_q <= RST_ZERO; w1_q <= RST_ZERO;
			lin_q <= RST_ZERO; pde_q <= RST_ZERO; ip_q <= RST_ZERO; sp_q <= RST_ZERO;
			phys_q <= RST_ZERO; cs_q <= 16'h0000; ss_q <= 16'h0000; flt_q <= FLT_NONE;
			cnt_q <= 4'h0; c32_q <= 1'b0; gate_q <= 1'b0; gate_dpl_q <= 2'h0;
			tss_cur_q <= RST_ZERO;
		end else begin
			st_q <= st_d; pe_q <= pe_d; pg_q <= pg_d;
			cr3_q <= cr3_d; gtab_q <= gtab_d; itab_q <= itab_d; ltab_q <= ltab_d;
			lsel_q <= lsel_d; tr_q <= tr_d; cpl_q <= cpl_d; op_q <= op_d;
			sel_q <= sel_d; off_q <= off_d; w0_q <= w0_d; w1_q <= w1_d;
			lin_q <= lin_d; pde_q <= pde_d; ip_q <= ip_d; sp_q <= sp_d;
			phys_q <= phys_d; cs_q <= cs_d; ss_q <= ss_d; flt_q <= flt_d;
			cnt_q <= cnt_d; c32_q <= c32_d; gate_q <= gate_d; gate_dpl_q <= gate_dpl_d;
			tss_cur_q <= tss_cur_d;
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign done_out      = (st_q == S_DONE);
	assign fault_out     = flt_q;
	assign phys_addr_out = phys_q;
	assign code_sel_out  = cs_q;
	assign ip_out        = ip_q;
	assign stack_sel_out = ss_q;
	assign stack_ptr_out = sp_q;
	assign cpl_out       = cpl_q;
	assign prot_mode_out = pe_q;
	assign code32_out    = c32_q;
endmodule

// ===== verification/pmsc_core_sva.sv
`timescale 1ns/1ps
module pmsc_core_chk
	import pmsc_pkg::*;
(
	// clock, reset and control
	input wire logic        sys_clk_in,
	input wire logic        arst_n_in,
	input wire logic        ctl_wr_in,
	input wire logic        prot_en_in,
	// request and memory port
	input wire logic        req_valid_in,
	input wire logic        req_ready_out,
	input wire logic [1:0]  req_op_in,
	input wire logic [15:0] req_sel_in,
	input wire logic [31:0] req_off_in,
	input wire logic        mem_rd_out,
	input wire logic        mem_wr_out,
	input wire logic [31:0] mem_addr_out,
	input wire logic        mem_ack_in,
	// results
	input wire logic        done_out,
	input wire logic [31:0] phys_addr_out,
	input wire logic [1:0]  cpl_out,
	input wire logic        prot_mode_out
);
	// ----------------------------------------
	// expected real-address result
	// ----------------------------------------
	default clocking @(posedge sys_clk_in); endclocking
	default disable iff (!arst_n_in);
	logic        take;
	logic [31:0] real_d;
	logic [31:0] real_q;
	assign take = req_valid_in && req_ready_out;
	always_comb begin
		real_d = real_q;
		if (take)
			real_d = {12'h000, req_sel_in, 4'h0} + req_off_in;
	end
	always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
		if (!arst_n_in)
			real_q <= RST_ZERO;
		else
			real_q <= real_d;
	end
	// ----------------------------------------
	// properties
	// ----------------------------------------
	a_reset_real_mode: assert property ($rose(arst_n_in) |-> !prot_mode_out)
		else $error("protected mode active right after reset");
	a_mode_needs_write: assert property ($rose(prot_mode_out) |->
		$past(ctl_wr_in && prot_en_in) || $past(ctl_wr_in && prot_en_in, 2))
		else $error("protected mode entered without a control write");
	a_real_addr_one: assert property (take && !prot_mode_out && req_op_in == 2'h0 |->
		##[1:2] (done_out && phys_addr_out == real_q))
		else $error("real-address result wrong or late");
	a_ctl_blocks_req: assert property (ctl_wr_in |-> !req_ready_out)
		else $error("request ready during control write");
	a_take_then_busy: assert property (take |=> !req_ready_out)
		else $error("second request accepted while busy");
	a_done_one_cycle: assert property (done_out |=> !done_out)
		else $error("done longer than one cycle");
	a_mem_req_held: assert property ((mem_rd_out || mem_wr_out) && !mem_ack_in |=>
		(mem_rd_out || mem_wr_out) && $stable(mem_addr_out))
		else $error("memory request dropped before acknowledge");
	a_rd_wr_apart: assert property (!(mem_rd_out && mem_wr_out))
		else $error("read and write at once");
	a_cpl_no_raise: assert property (cpl_out <= $past(cpl_out))
		else $error("privilege level made less privileged");
	a_answer_bounded: assert property (take |-> ##[1:400] done_out)
		else $error("request never completed");
endmodule
bind pmsc_core pmsc_core_chk chk_u (.sys_clk_in, .arst_n_in, .ctl_wr_in, .prot_en_in, .req_valid_in,
	.req_ready_out, .req_op_in, .req_sel_in, .req_off_in, .mem_rd_out, .mem_wr_out, .mem_addr_out,
	.mem_ack_in, .done_out, .phys_addr_out, .cpl_out, .prot_mode_out);

// ===== verification/pmsc_mem_model.sv
`timescale 1ns/1ps
module pmsc_mem_model
	import pmsc_pkg::*;
(
	// clock and reset
	input wire logic         sys_clk_in,
	input wire logic         arst_n_in,
	// memory port
	input wire logic         mem_rd_in,
	input wire logic         mem_wr_in,
	input wire logic [31:0]  mem_addr_in,
	input wire logic [31:0]  mem_wdata_in,
	input wire logic         slow_in,
	output logic             mem_ack_out,
	output logic [31:0]      mem_rdata_out
);
	// ----------------------------------------
	// descriptor, state and page tables
	// ----------------------------------------
	logic [31:0] mem [logic [31:0]];
	logic [1:0]  wait_q;
	int          wr_cnt;
	task automatic put(input logic [31:0] a, input logic [31:0] d);
		mem[a] = d;
	endtask
	// read data is only meaningful with ack; it toggles while neither a request nor an ack is present so stale values never pass
	always @(posedge sys_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			mem_ack_out <= 1'b0;
			wait_q <= 2'h0;
			wr_cnt = 0;
		end else begin
			mem_ack_out <= 1'b0;
			if ((mem_rd_in || mem_wr_in) && !mem_ack_out) begin
				if (wait_q >= (slow_in ? 2'h3 : 2'h0)) begin
					mem_ack_out <= 1'b1;
					wait_q <= 2'h0;
					if (mem_wr_in) begin
						mem[mem_addr_in] = mem_wdata_in;
						wr_cnt++;
					end
					mem_rdata_out <= mem.exists(mem_addr_in) ? mem[mem_addr_in] : 32'h0;
				end else
					wait_q <= wait_q + 2'h1;
			end else if (!mem_ack_out)
				mem_rdata_out <= ~mem_rdata_out;
		end
	end
endmodule

// ===== verification/protected_mode_segment_task_control_test.sv
`timescale 1ns/1ps
module protected_mode_segment_task_control_test;
	import pmsc_pkg::*;
	// ----------------------------------------
	// stimulus signals
	// ----------------------------------------
	logic        sys_clk_in     = 1'b0;
	logic        arst_n_in      = 1'b0;
	logic        ctl_wr_in      = 1'b0;
	logic        prot_en_in     = 1'b0;
	logic        paging_en_in   = 1'b0;
	logic [31:0] dir_base_in    = 32'h0000_8000;
	logic [31:0] gtab_base_in   = 32'h0000_1000;
	logic [31:0] itab_base_in   = 32'h0000_2000;
	logic [15:0] ltab_sel_in    = 16'h0000;
	logic [31:0] ltab_base_in   = 32'h0000_0000;
	logic [15:0] task_sel_in    = 16'h0000;
	logic        req_valid_in   = 1'b0;
	logic [1:0]  req_op_in      = 2'h0;
	logic [15:0] req_sel_in     = 16'h0000;
	logic [31:0] req_off_in     = 32'h0000_0000;
	logic [7:0]  req_vec_in     = 8'h00;
	logic [1:0]  req_vec_src_in = 2'h0;
	logic        slow_in        = 1'b0;
	logic        req_ready_out, mem_rd_out, mem_wr_out, mem_ack_in, done_out, prot_mode_out, code32_out;
	logic [31:0] mem_addr_out, mem_wdata_out, mem_rdata_in, phys_addr_out, ip_out, stack_ptr_out;
	logic [15:0] code_sel_out, stack_sel_out;
	logic [2:0]  fault_out;
	logic [1:0]  cpl_out;
	int          err_count   = 0;
	int          check_count = 0;
	pmsc_core dut_u (.sys_clk_in, .arst_n_in, .ctl_wr_in, .prot_en_in, .paging_en_in, .dir_base_in,
		.gtab_base_in, .itab_base_in, .ltab_sel_in, .ltab_base_in, .task_sel_in, .req_valid_in,
		.req_ready_out, .req_op_in, .req_sel_in, .req_off_in, .req_vec_in, .req_vec_src_in, .mem_rd_out,
		.mem_wr_out, .mem_addr_out, .mem_wdata_out, .mem_ack_in, .mem_rdata_in, .done_out, .fault_out,
		.phys_addr_out, .code_sel_out, .ip_out, .stack_sel_out, .stack_ptr_out, .cpl_out, .prot_mode_out,
		.code32_out);
	pmsc_mem_model mem_u (.sys_clk_in, .arst_n_in, .mem_rd_in(mem_rd_out), .mem_wr_in(mem_wr_out),
		.mem_addr_in(mem_addr_out), .mem_wdata_in(mem_wdata_out), .slow_in,
		.mem_ack_out(mem_ack_in), .mem_rdata_out(mem_rdata_in));
	// ----------------------------------------
	// shared tasks
	// ----------------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			err_count++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic ctl(input logic pe, input logic pg);
		@(posedge sys_clk_in);
		ctl_wr_in <= 1'b1;
		prot_en_in <= pe;
		paging_en_in <= pg;
		@(posedge sys_clk_in);
		ctl_wr_in <= 1'b0;
	endtask
	task automatic req(input logic [1:0] op, input logic [15:0] sel, input logic [31:0] off,
		input logic [7:0] vec, input logic [1:0] src);
		int n;
		@(posedge sys_clk_in);
		req_valid_in <= 1'b1;
		req_op_in <= op;
		req_sel_in <= sel;
		req_off_in <= off;
		req_vec_in <= vec;
		req_vec_src_in <= src;
		n = 0;
		do begin
			@(negedge sys_clk_in);
			n++;
		end while (req_ready_out !== 1'b1 && n < 50);
		@(posedge sys_clk_in);
		req_valid_in <= 1'b0;
		n = 0;
		do begin
			@(negedge sys_clk_in);
			n++;
		end while (done_out !== 1'b1 && n < 400);
		chk({31'h0, done_out}, 32'h1);
	endtask
	task automatic final_report();
		if (err_count == 0 && check_count > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic t_real();
		chk({26'h0, prot_mode_out, cpl_out, fault_out}, 32'h0);
		req(2'h0, 16'h1234, 32'h0000_0010, 8'h00, 2'h0);
		chk(phys_addr_out, 32'h0001_2350);
	endtask
	task automatic t_prot();
		mem_u.put(32'h0000_1008, 32'h3000_FFFF);
		mem_u.put(32'h0000_100C, 32'h0000_9200);
		ctl(1'b1, 1'b0);
		req(2'h0, 16'h0008, 32'h0000_0020, 8'h00, 2'h0);
		chk({31'h0, prot_mode_out}, 32'h1);
		chk(phys_addr_out, 32'h0000_3020);
		chk({29'h0, fault_out}, {29'h0, FLT_NONE});
		req(2'h0, 16'h0028, 32'h0000_0000, 8'h00, 2'h0);
		chk({29'h0, fault_out}, {29'h0, FLT_NOTP});
	endtask
	task automatic t_call();
		mem_u.put(32'h0000_1010, 32'h0018_0034);
		mem_u.put(32'h0000_1014, 32'h0012_EC00);
		mem_u.put(32'h0000_1018, 32'h5000_FFFF);
		mem_u.put(32'h0000_101C, 32'h0040_9A00);
		slow_in <= 1'b1;
		req(2'h1, 16'h0010, 32'h0000_0000, 8'h00, 2'h0);
		slow_in <= 1'b0;
		chk({16'h0, code_sel_out}, 32'h0000_0018);
		chk(ip_out, 32'h0012_0034);
		chk({31'h0, code32_out}, 32'h1);
		chk({30'h0, cpl_out}, 32'h0);
	endtask
	task automatic t_intr();
		mem_u.put(32'h0000_2018, 32'h0018_0400);
		mem_u.put(32'h0000_201C, 32'h0000_8E00);
		for (int s = 0; s < 3; s++) begin
			req(2'h2, 16'h0000, 32'h0000_0000, 8'h03, s[1:0]);
			chk(ip_out, 32'h0000_0400);
			chk({16'h0, code_sel_out}, 32'h0000_0018);
		end
	endtask
	task automatic t_task();
		int w;
		mem_u.put(32'h0000_1020, 32'h6000_0067);
		mem_u.put(32'h0000_1024, 32'h0000_8900);
		mem_u.put(32'h0000_601C, 32'h0000_8000);
		mem_u.put(32'h0000_6020, 32'h0000_0777);
		w = mem_u.wr_cnt;
		req(2'h3, 16'h0020, 32'h0000_0000, 8'h00, 2'h0);
		chk(ip_out, 32'h0000_0777);
		chk({31'h0, mem_u.wr_cnt > w}, 32'h1);
	endtask
	task automatic t_page();
		mem_u.put(32'h0000_8000, 32'h0000_9001);
		mem_u.put(32'h0000_900C, 32'h0000_A001);
		ctl(1'b1, 1'b1);
		req(2'h0, 16'h0008, 32'h0000_0020, 8'h00, 2'h0);
		chk(phys_addr_out, 32'h0000_A020);
		req(2'h0, 16'h0008, 32'h0040_0020, 8'h00, 2'h0);
		chk({29'h0, fault_out}, {29'h0, FLT_PAGE});
	endtask
	// ----------------------------------------
	// clock, sequence and watchdog
	// ----------------------------------------
	initial begin
		forever #25 sys_clk_in = ~sys_clk_in;
	end
	initial begin
		repeat (3) @(posedge sys_clk_in);
		arst_n_in <= 1'b1;
		@(negedge sys_clk_in);
		t_real();
		t_prot();
		t_call();
		t_intr();
		t_task();
		t_page();
		final_report();
	end
	initial begin
		#1000000;
		err_count++;
		final_report();
	end
endmodule
